/* hw/hram_pkg.sv */
package hram_pkg;
  // Host-visible byte offsets
  localparam logic [9:0]  HRAM_MODE_OFS   = 10'h000;
  localparam logic [9:0]  HRAM_PTR_OFS    = 10'h002;
  localparam logic [9:0]  HRAM_WIN_OFS    = 10'h004;
  // Size of the host window in each mode, in bytes
  localparam logic [10:0] HRAM_DIRECT_SPAN   = 11'h400;
  localparam logic [10:0] HRAM_INDIRECT_SPAN = 11'h006;
  // Bus and field layout
  localparam int          HRAM_ADDR_W     = 10;
  localparam int          HRAM_DATA_W     = 16;
  localparam int          HRAM_WORDS      = 512;
  localparam int          HRAM_IND_BIT    = 0;
  // Reset values and the zero fill byte for narrow reads
  localparam logic [15:0] HRAM_MODE_RST   = 16'h0000;
  localparam logic [15:0] HRAM_PTR_RST    = 16'h0000;
  localparam logic [15:0] HRAM_RF_RST     = 16'h0000;
  localparam logic [7:0]  HRAM_ZERO_BYTE  = 8'h00;
endpackage

/* hw/hram_regfile.sv */
`timescale 1ns/100ps
// Internal register space behind the host port, stored as big-endian words
module hram_regfile (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Write port with byte lanes
  input  wire logic [8:0]  i_waddr,
  input  wire logic        i_we_hi,
  input  wire logic        i_we_lo,
  input  wire logic [15:0] i_wdata,
  // Read port
  input  wire logic [8:0]  i_raddr,
  output logic      [15:0] o_rdata
);
  import hram_pkg::*;

  logic [15:0] mem_q [HRAM_WORDS];

  // The low-offset byte of each word is the high byte
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < HRAM_WORDS; i++) begin
        mem_q[i] <= HRAM_RF_RST;
      end
    end else begin
      if (i_we_hi) begin
        mem_q[i_waddr][15:8] <= i_wdata[15:8];
      end
      if (i_we_lo) begin
        mem_q[i_waddr][7:0] <= i_wdata[7:0];
      end
    end
  end

  assign o_rdata = mem_q[i_raddr];
endmodule

/* hw/hram_mapper.sv */
// Behaviour
// (RL1) Direct mode maps mode word, common and socket registers consecutively, two bytes apart.
// (RL2) Host reserves 0x400 bytes of address space for direct mode.
// (RL3) Indirect mode reaches internal registers only through pointer and data window.
// (RL4) Indirect mode exposes only mode word, pointer and window: 0x06 bytes.
// (RL5) Mode word bit 0 clear selects direct, set selects indirect addressing.
// (RL6) Indirect write: host loads pointer with offset, then writes the window.
// (RL7) Indirect read: pointer loaded, window read returns the addressed register.
// (RL8) Offsets advance two bytes per access on 16-bit bus, one on 8-bit.
// (RL9) Registers are 1, 2, 4 or 6 bytes, spanning consecutive byte offsets.
// (RL10) Host location is base plus register offset.
// (RL11) Multi-byte registers are big-endian: lowest offset holds the most significant byte.
// (RL12) Mode word high byte sits at 0x000, low byte at 0x001.
// (RL13) Register bit 15 is bit 7 of low-offset byte; bit 0 of high-offset byte.
// (RL14) Pointer at 0x002 and window at 0x004 work only in indirect mode.
// (RL15) Internal registers sit in host space directly, else in internal space.
// (RL16) Mode word stays host-addressable in both modes.
// (RL17) Window accesses follow the same width and byte order as direct accesses.
`timescale 1ns/100ps
module hram_mapper (
  // Clock and reset
  input  wire logic                             i_clk,
  input  wire logic                             i_sys_rst,
  // Host bus width strap: high for an 8-bit data bus
  input  wire logic                             i_bus_8bit,
  // Host parallel bus
  input  wire logic                             i_cs,
  input  wire logic                             i_rd,
  input  wire logic                             i_wr,
  input  wire logic [hram_pkg::HRAM_ADDR_W-1:0] i_addr,
  input  wire logic [hram_pkg::HRAM_DATA_W-1:0] i_data,
  output logic      [hram_pkg::HRAM_DATA_W-1:0] o_data,
  output logic                                  o_data_oe_n,
  output logic                                  o_rd_valid,
  // Status
  output logic                                  o_indirect
);
  import hram_pkg::*;

  // Merge a host write into a word by byte lane
  function automatic logic [15:0] merge_lanes(input logic [15:0] old_w, input logic [15:0] new_w,
                                              input logic hi, input logic lo);
    merge_lanes = {hi ? new_w[15:8] : old_w[15:8], lo ? new_w[7:0] : old_w[7:0]};
  endfunction

  // Pick what the host sees of a word on its bus width
  function automatic logic [15:0] bus_view(input logic [15:0] w, input logic narrow, input logic a0);
    if (!narrow) begin
      bus_view = w;
    end else begin
      bus_view = {HRAM_ZERO_BYTE, a0 ? w[7:0] : w[15:8]};
    end
  endfunction

  // Byte offset to word index; bit 0 only picks a lane on a narrow bus
  function automatic logic [8:0] word_of(input logic [9:0] ofs);
    word_of = ofs[9:1];
  endfunction

  logic [15:0] mode_q;
  logic [15:0] mode_d;
  logic [15:0] ptr_q;
  logic [15:0] ptr_d;
  logic [15:0] rd_data_q;
  logic        rd_valid_q;

  wire         wr_acc   = i_cs & i_wr;
  wire         rd_acc   = i_cs & i_rd & ~i_wr;
  wire         indirect = mode_q[HRAM_IND_BIT]; // RL5
  wire [8:0]   host_wd  = word_of(i_addr);
  wire         is_mode  = host_wd == word_of(HRAM_MODE_OFS); // RL12 RL16
  wire         is_ptr   = indirect & (host_wd == word_of(HRAM_PTR_OFS)); // RL14
  wire         is_win   = indirect & (host_wd == word_of(HRAM_WIN_OFS)); // RL14
  // Word behind the window; the host's own lane bit picks the byte on a narrow bus
  wire [8:0]   win_wd   = word_of(ptr_q[9:0]); // RL3 RL17
  wire         win_mode = is_win & (win_wd == word_of(HRAM_MODE_OFS));
  wire         win_rf   = is_win & ~win_mode; // RL7
  wire         dir_rf   = ~indirect & ~is_mode; // RL1 RL15
  wire         tgt_rf   = dir_rf | win_rf; // RL4
  wire [8:0]   rf_wd    = indirect ? win_wd : host_wd; // RL9
  // A narrow bus touches one byte per access, a wide bus both
  wire         lane_hi  = ~i_bus_8bit | ~i_addr[0]; // RL8 RL11 RL13
  wire         lane_lo  = ~i_bus_8bit | i_addr[0]; // RL8 RL11 RL13
  wire [15:0]  wr_word  = i_bus_8bit ? {i_data[7:0], i_data[7:0]} : i_data;
  wire         mode_wr  = wr_acc & (is_mode | win_mode);
  wire         ptr_wr   = wr_acc & is_ptr; // RL6
  wire         rf_we    = wr_acc & tgt_rf;
  wire [15:0]  rf_rdata;
  wire [15:0]  rd_word  = (is_mode | win_mode) ? mode_q :
                          is_ptr               ? ptr_q  :
                          tgt_rf               ? rf_rdata : 16'h0000; // RL4

  assign mode_d = mode_wr ? merge_lanes(mode_q, wr_word, lane_hi, lane_lo) : mode_q;
  assign ptr_d  = ptr_wr ? merge_lanes(ptr_q, wr_word, lane_hi, lane_lo) : ptr_q;

  hram_regfile u_regs (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_waddr   (rf_wd),
    .i_we_hi   (rf_we & lane_hi),
    .i_we_lo   (rf_we & lane_lo),
    .i_wdata   (wr_word),
    .i_raddr   (rf_wd),
    .o_rdata   (rf_rdata)
  );

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_q     <= HRAM_MODE_RST;
      ptr_q      <= HRAM_PTR_RST;
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      mode_q     <= mode_d;
      ptr_q      <= ptr_d;
      rd_valid_q <= rd_acc;
      if (rd_acc) begin
        rd_data_q <= bus_view(rd_word, i_bus_8bit, i_addr[0]); // RL7 RL11
      end
    end
  end

  assign o_data      = rd_data_q;
  assign o_rd_valid  = rd_valid_q;
  assign o_data_oe_n = ~rd_valid_q;
  assign o_indirect  = indirect;

  a_mode_read_back: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL12
    rd_acc && !i_bus_8bit && i_addr[9:1] == 9'h000 |=> o_data == $past(mode_q))
    else $error("mode word read back wrong");

  a_high_byte_first: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL11
    rd_acc && i_bus_8bit && i_addr == 10'h000 |=> o_data == {8'h00, $past(mode_q[15:8])})
    else $error("low offset byte is not the high byte");

  a_low_byte_last: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL13
    rd_acc && i_bus_8bit && i_addr == 10'h001 |=> o_data == {8'h00, $past(mode_q[7:0])})
    else $error("high offset byte is not the low byte");

  a_indirect_hides: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL4
    rd_acc && indirect && i_addr >= 10'h006 |=> o_data == 16'h0000)
    else $error("register visible beyond indirect span");

  a_ptr_inert_direct: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL14
    wr_acc && !indirect |=> $stable(ptr_q))
    else $error("pointer changed in direct mode");

  a_mode_selects: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL5
    wr_acc && !i_bus_8bit && i_addr[9:1] == 9'h000 |=> o_indirect == $past(i_data[0]))
    else $error("mode bit 0 does not select addressing");

  a_window_read: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL7
    rd_acc && is_win && !i_bus_8bit && ptr_q[9:1] != 9'h000 |=> o_data == $past(rf_rdata))
    else $error("window read not from pointed register");

  a_read_answer: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL8
    rd_acc && i_bus_8bit |=> o_rd_valid && !o_data_oe_n && o_data[15:8] == 8'h00)
    else $error("narrow read answer wrong");

  a_ptr_loads: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL3
    wr_acc && indirect && !i_bus_8bit && i_addr[9:1] == 9'h001 |=> ptr_q == $past(i_data))
    else $error("pointer not loaded in indirect mode");

  // Outputs go idle on the edge after reset, so a stale read cannot leak out
  a_reset_idle: assert property (@(posedge i_clk) // RL5
    i_sys_rst |=> !o_rd_valid && o_data_oe_n && !o_indirect)
    else $error("outputs not idle after reset");

  a_valid_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL7
    !rd_acc |=> !o_rd_valid)
    else $error("read valid without a read");

  a_data_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL7
    !rd_acc |=> o_data == $past(o_data))
    else $error("read data changed without a read");

  // Indirect mode must drop writes beyond the short span rather than alias them
  a_span_drops: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL3
    wr_acc && indirect && {1'b0, i_addr} >= HRAM_INDIRECT_SPAN |-> !rf_we && !mode_wr && !ptr_wr)
    else $error("write landed beyond indirect span");

  a_direct_lands: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL1
    wr_acc && !indirect && i_addr[9:1] != 9'h000 |-> rf_we && rf_wd == i_addr[9:1])
    else $error("direct write missed its word");

  a_window_target: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL17
    (wr_acc || rd_acc) && is_win && ptr_q[9:1] != 9'h000 |-> tgt_rf && rf_wd == ptr_q[9:1])
    else $error("window does not reach pointed word");

  a_window_mode: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL16
    rd_acc && is_win && !i_bus_8bit && ptr_q[9:1] == 9'h000 |=> o_data == $past(mode_q))
    else $error("window at offset zero misses mode word");

  a_narrow_lanes: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL8
    wr_acc && i_bus_8bit |-> lane_hi != lane_lo)
    else $error("narrow write touches both lanes");

  a_wide_lanes: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL9
    wr_acc && !i_bus_8bit |-> lane_hi && lane_lo)
    else $error("wide write misses a lane");

  a_ptr_byte_load: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL13
    wr_acc && indirect && i_bus_8bit && i_addr == 10'h003 |=>
      ptr_q == {$past(ptr_q[15:8]), $past(i_data[7:0])})
    else $error("pointer low byte not loaded");

  a_narrow_rf_hi: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL11
    rd_acc && i_bus_8bit && !i_addr[0] && tgt_rf |=> o_data == {8'h00, $past(rf_rdata[15:8])})
    else $error("even offset does not return the high byte");

  a_narrow_rf_lo: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL13
    rd_acc && i_bus_8bit && i_addr[0] && tgt_rf |=> o_data == {8'h00, $past(rf_rdata[7:0])})
    else $error("odd offset does not return the low byte");
endmodule

/* testbench/hram_host_model.sv */
`timescale 1ns/100ps
// Host bus master; base location is zero, so offsets go out unchanged
module hram_host_model (
  // Clock
  input  wire logic                             i_clk,
  // Read return
  input  wire logic [hram_pkg::HRAM_DATA_W-1:0] i_rdata,
  input  wire logic                             i_rd_valid,
  input  wire logic                             i_data_oe_n,
  // Bus request
  output logic                                  o_cs,
  output logic                                  o_rd,
  output logic                                  o_wr,
  output logic      [hram_pkg::HRAM_ADDR_W-1:0] o_addr,
  output logic      [hram_pkg::HRAM_DATA_W-1:0] o_data
);
  import hram_pkg::*;
  initial begin
    o_cs = 1'b0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = 10'h000;
    o_data = 16'h0000;
  end
  // Offsets stay inside the direct span of 0x400 bytes
  task automatic wr(input logic [HRAM_ADDR_W-1:0] a, input logic [HRAM_DATA_W-1:0] d);
    @(negedge i_clk);
    o_cs = 1'b1;
    o_wr = 1'b1;
    o_addr = a;
    o_data = d;
    @(negedge i_clk);
    o_cs = 1'b0;
    o_wr = 1'b0;
    // Released data lines must not keep the last value
    o_data = ~d;
  endtask
  // Pointer is always loaded by wr before the window is used
  task automatic rd(input logic [HRAM_ADDR_W-1:0] a, output logic [15:0] d, output logic [1:0] f);
    @(negedge i_clk);
    o_cs = 1'b1;
    o_rd = 1'b1;
    o_addr = a;
    // The answer stands one cycle only; take it mid-cycle before letting go
    @(negedge i_clk);
    d = i_rdata;
    f = {i_rd_valid, i_data_oe_n};
    o_cs = 1'b0;
    o_rd = 1'b0;
  endtask
endmodule

/* testbench/tb.sv */
`timescale 1ns/100ps
module tb;
  import hram_pkg::*;
  logic                   clk, rst, bus8, cs, rd, wr, oe_n, vld, indirect_select_bit;
  logic [HRAM_ADDR_W-1:0] addr;
  logic [HRAM_DATA_W-1:0] wdat, rdat;
  int                     err_count, checks_done;
  hram_mapper u_hram_mapper (.i_clk(clk), .i_sys_rst(rst), .i_bus_8bit(bus8), .i_cs(cs), .i_rd(rd), .i_wr(wr),
    .i_addr(addr), .i_data(wdat), .o_data(rdat), .o_data_oe_n(oe_n), .o_rd_valid(vld), .o_indirect(indirect_select_bit));
  hram_host_model u_hram_host_model (.i_clk(clk), .i_rdata(rdat), .i_rd_valid(vld), .i_data_oe_n(oe_n),
    .o_cs(cs), .o_rd(rd), .o_wr(wr), .o_addr(addr), .o_data(wdat));
  always #4 clk = ~clk;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Read plus check of the one-cycle valid and driven data pins
  task automatic rdc(input string what, input logic [9:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic [1:0]  f;
    u_hram_host_model.rd(a, d, f);
    chk({what, " flags"}, 16'h0002, {14'h0000, f});
    chk(what, exp, d);
  endtask
  task automatic t_reset;
    chk("indirect", 16'h0000, {15'h0000, indirect_select_bit});
    rdc("mode", HRAM_MODE_OFS, HRAM_MODE_RST);
  endtask
  task automatic t_direct;
    u_hram_host_model.wr(10'h010, 16'h1234);
    u_hram_host_model.wr(10'h3fe, 16'h5a5a);
    u_hram_host_model.wr(HRAM_PTR_OFS, 16'h00aa);
    rdc("w010", 10'h011, 16'h1234);
    rdc("w3fe", 10'h3fe, 16'h5a5a);
    rdc("ptr direct", HRAM_PTR_OFS, 16'h00aa);
  endtask
  task automatic t_bytes;
    @(negedge clk);
    bus8 = 1'b1;
    u_hram_host_model.wr(10'h020, 16'h00ab);
    u_hram_host_model.wr(10'h021, 16'h00cd);
    rdc("hi byte", 10'h020, 16'h00ab);
    rdc("lo byte", 10'h021, 16'h00cd);
    @(negedge clk);
    bus8 = 1'b0;
    rdc("word", 10'h020, 16'habcd);
  endtask
  task automatic t_indirect;
    u_hram_host_model.wr(HRAM_MODE_OFS, 16'h0001);
    @(negedge clk);
    chk("indirect", 16'h0001, {15'h0000, indirect_select_bit});
    u_hram_host_model.wr(HRAM_PTR_OFS, 16'h0002);
    u_hram_host_model.wr(HRAM_WIN_OFS, 16'hffff);
    rdc("window", HRAM_WIN_OFS, 16'hffff);
    u_hram_host_model.wr(HRAM_PTR_OFS, 16'h0020);
    rdc("win20", HRAM_WIN_OFS, 16'habcd);
    rdc("outside", 10'h010, 16'h0000);
    u_hram_host_model.wr(10'h010, 16'h7777);
    rdc("mode kept", HRAM_MODE_OFS, 16'h0001);
    u_hram_host_model.wr(HRAM_MODE_OFS, 16'h0000);
    rdc("direct again", 10'h010, 16'h1234);
    rdc("flags word", 10'h002, 16'hffff);
  endtask
  task automatic t_narrow_ind;
    u_hram_host_model.wr(HRAM_MODE_OFS, 16'h0001);
    u_hram_host_model.wr(HRAM_PTR_OFS, 16'h0000);
    rdc("win mode", HRAM_WIN_OFS, 16'h0001);
    @(negedge clk);
    bus8 = 1'b1;
    u_hram_host_model.wr(10'h002, 16'h0000);
    u_hram_host_model.wr(10'h003, 16'h0020);
    rdc("win hi", HRAM_WIN_OFS, 16'h00ab);
    rdc("win lo", 10'h005, 16'h00cd);
    rdc("mode hi", HRAM_MODE_OFS, 16'h0000);
    rdc("mode lo", 10'h001, 16'h0001);
    @(negedge clk);
    bus8 = 1'b0;
  endtask
  task automatic t_mid_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("indirect after reset", 16'h0000, {15'h0000, indirect_select_bit});
    chk("data after reset", 16'h0000, rdat);
    rdc("w010 after reset", 10'h010, HRAM_RF_RST);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    bus8 = 1'b0;
    err_count = 0;
    checks_done = 0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_direct;
    t_bytes;
    t_indirect;
    t_narrow_ind;
    t_mid_reset;
    close_out;
  end
  // About 80 cycles of traffic; allow a wide margin
  initial begin
    #(8 * 3000);
    err_count++;
    close_out;
  end
endmodule
